// ==== verilog/acc_pkg.sv ====
// Package of register layout, reset values and codes for the comparator control block
`default_nettype none

package acc_pkg;

    // =====================================================================
    // Register map
    // =====================================================================
    localparam logic [7:0] ADDR_CONTROL    = 8'h00;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_MASK   = 8'h08;

    // =====================================================================
    // Control register fields
    // =====================================================================
    localparam int POS_ENABLE      = 15;
    localparam int POS_PIN_DRIVE   = 14;
    localparam int POS_INVERT      = 13;
    localparam int POS_RESULT      = 8;
    localparam int POS_EDGE_LO     = 6;
    localparam int POS_POS_SEL     = 4;
    localparam int POS_NEG_SEL_LO  = 0;

    // Writable bits of the control register
    localparam logic [31:0] CONTROL_WR_MASK = 32'h0000_E0D3;

    // Reset values (not given by the device description; chosen plainly)
    localparam logic [1:0]  RST_EDGE_SEL = 2'h3;
    localparam logic [1:0]  RST_NEG_SEL  = 2'h3;

    // =====================================================================
    // Interrupt status bits
    // =====================================================================
    localparam int STAT_EDGE = 0;
    localparam int STAT_W    = 1;

    // Edge select codes
    typedef enum logic [1:0] {
        ACC_EDGE_OFF  = 2'h0,
        ACC_EDGE_RISE = 2'h1,
        ACC_EDGE_FALL = 2'h2,
        ACC_EDGE_ANY  = 2'h3
    } acc_edge_e;

    // Negative input source codes
    typedef enum logic [1:0] {
        ACC_NEG_OWN_NEG   = 2'h0,
        ACC_NEG_OWN_POS   = 2'h1,
        ACC_NEG_OTHER_POS = 2'h2,
        ACC_NEG_BANDGAP   = 2'h3
    } acc_neg_e;

endpackage : acc_pkg

`default_nettype wire

// ==== verilog/acc_sync.sv ====
// Three-stage synchroniser with agreement filter for the raw comparator level
`default_nettype none

module acc_sync (
    input  wire logic mclk,
    input  wire logic rstn,
    input  wire logic din,
    output logic      dout
);

    // =====================================================================
    // Sampling chain
    // =====================================================================
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic q;
    } acc_sync_s;

    acc_sync_s r;
    acc_sync_s next_r;

    // Shift chain; output changes once stages two and three agree
    always_comb begin
        next_r    = r;
        next_r.s1 = din;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        if (r.s2 == r.s3) begin
            next_r.q = r.s3;
        end
    end

    // State register
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign dout = r.q;

endmodule : acc_sync

`default_nettype wire

// ==== verilog/acc_top.sv ====
// Control, status and interrupt logic around one analog voltage comparator
// Notes on behaviour
// - Enable bit 15 writes also rewrite all other fields; clear disables comparator.
// - Pin drive enable bit 14 puts result on the output pin.
// - Invert bit 13 inverts comparator output when set.
// - Read-only bit 8 shows current comparator output level.
// - Edge select: 11 any, 10 falling, 01 rising, 00 interrupts off.
// - Inversion also feeds edge detector, so edges swap when inverted.
// - Positive select bit 4: 1 internal reference, 0 positive pin.
// - Negative select bits 1-0: band-gap, other pin, own positive, own negative.
// - Unimplemented bits 31-16, 12-9, 5, 3-2 read as zero.
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
`default_nettype none

module acc_top (
    input  wire logic        mclk,
    input  wire logic        rstn,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Analog core side
    input  wire logic        compare_raw,
    output logic             comparator_enable,
    output logic             positive_input_select,
    output logic [1:0]       negative_input_select,
    // Output pin
    output logic             comparator_output_pin,
    output logic             comparator_output_pin_oe,
    // Interrupt
    output logic             irq_pulse,
    output logic             irq
);

    // =====================================================================
    // State
    // =====================================================================
    typedef struct packed {
        logic        enable;
        logic        pin_drive_enable;
        logic        output_invert;
        logic [1:0]  irq_edge_select;
        logic        positive_input_select;
        logic [1:0]  negative_input_select;
        logic        prev_out;
        logic [acc_pkg::STAT_W-1:0] irq_status;
        logic [acc_pkg::STAT_W-1:0] irq_mask;
        logic [31:0] rdata;
        logic        pin;
        logic        pin_oe;
        logic        pulse;
        logic        irq;
    } acc_top_s;

    acc_top_s r;
    acc_top_s next_r;

    logic compare_sync;

    // Raw comparator level brought into mclk domain
    acc_sync u_sync (
        .mclk (mclk),
        .rstn (rstn),
        .din  (compare_raw),
        .dout (compare_sync)
    );

    // =====================================================================
    // Helpers
    // =====================================================================
    // Control register image with unimplemented bits forced to zero
    function automatic logic [31:0] control_image(input acc_top_s s, input logic result);
        logic [31:0] v;
        v = 32'h0000_0000;
        v[acc_pkg::POS_ENABLE]    = s.enable;
        v[acc_pkg::POS_PIN_DRIVE] = s.pin_drive_enable;
        v[acc_pkg::POS_INVERT]    = s.output_invert;
        v[acc_pkg::POS_RESULT]    = result;
        v[acc_pkg::POS_EDGE_LO +: 2] = s.irq_edge_select;
        v[acc_pkg::POS_POS_SEL]   = s.positive_input_select;
        v[acc_pkg::POS_NEG_SEL_LO +: 2] = s.negative_input_select;
        return v;
    endfunction : control_image

    // =====================================================================
    // Next state
    // =====================================================================
    logic        cur_out;
    logic        rise;
    logic        fall;
    logic        hit;
    logic [31:0] wmask;

    // Comparator path, edge detection, register access
    always_comb begin
        next_r = r;
        wmask  = reg_wdata & acc_pkg::CONTROL_WR_MASK;
        // Output after polarity; gated low while disabled
        cur_out = r.enable & (compare_sync ^ r.output_invert);
        rise    = cur_out & ~r.prev_out;
        fall    = ~cur_out & r.prev_out;
        unique case (acc_pkg::acc_edge_e'(r.irq_edge_select))
            acc_pkg::ACC_EDGE_OFF:  hit = 1'b0;
            acc_pkg::ACC_EDGE_RISE: hit = rise;
            acc_pkg::ACC_EDGE_FALL: hit = fall;
            acc_pkg::ACC_EDGE_ANY:  hit = rise | fall;
        endcase
        next_r.prev_out = cur_out;
        next_r.pulse    = hit;

        // Pin drive follows pin drive enable bit
        next_r.pin    = cur_out & r.pin_drive_enable;
        next_r.pin_oe = r.pin_drive_enable;

        // Control write: every field written independently of the enable bit
        if (reg_wr && reg_addr == acc_pkg::ADDR_CONTROL) begin
            next_r.enable           = wmask[acc_pkg::POS_ENABLE];
            next_r.pin_drive_enable = wmask[acc_pkg::POS_PIN_DRIVE];
            next_r.output_invert    = wmask[acc_pkg::POS_INVERT];
            next_r.irq_edge_select  = wmask[acc_pkg::POS_EDGE_LO +: 2];
            next_r.positive_input_select = wmask[acc_pkg::POS_POS_SEL];
            next_r.negative_input_select = wmask[acc_pkg::POS_NEG_SEL_LO +: 2];
        end
        if (reg_wr && reg_addr == acc_pkg::ADDR_IRQ_MASK) begin
            next_r.irq_mask = reg_wdata[acc_pkg::STAT_W-1:0];
        end

        // Read data, one cycle after the strobe; unmapped reads zero
        next_r.rdata = 32'h0000_0000;
        if (reg_rd) begin
            unique case (reg_addr)
                acc_pkg::ADDR_CONTROL:    next_r.rdata = control_image(r, cur_out);
                acc_pkg::ADDR_IRQ_STATUS: next_r.rdata = {31'h0000_0000, r.irq_status};
                acc_pkg::ADDR_IRQ_MASK:   next_r.rdata = {31'h0000_0000, r.irq_mask};
                default:                  next_r.rdata = 32'h0000_0000;
            endcase
        end

        // Sticky status: read clears, a new event in that cycle wins
        if (reg_rd && reg_addr == acc_pkg::ADDR_IRQ_STATUS) begin
            next_r.irq_status = '0;
        end
        if (hit) begin
            next_r.irq_status[acc_pkg::STAT_EDGE] = 1'b1;
        end
        next_r.irq = |(next_r.irq_status & next_r.irq_mask);
    end

    // State register
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            r                 <= '0;
            r.irq_edge_select <= acc_pkg::RST_EDGE_SEL;
            r.negative_input_select <= acc_pkg::RST_NEG_SEL;
        end else begin
            r <= next_r;
        end
    end

    // =====================================================================
    // Outputs, all from flip-flops
    // =====================================================================
    assign reg_rdata                = r.rdata;
    assign comparator_enable        = r.enable;
    assign positive_input_select    = r.positive_input_select;
    assign negative_input_select    = r.negative_input_select;
    assign comparator_output_pin    = r.pin;
    assign comparator_output_pin_oe = r.pin_oe;
    assign irq_pulse                = r.pulse;
    assign irq                      = r.irq;

endmodule : acc_top

`default_nettype wire

// ==== bench/acc_cmp_model.sv ====
// Behavioural analog comparator core with its input routing
`default_nettype none
module acc_cmp_model #(
    parameter int VREF_MV = 1650,
    parameter int BG_MV   = 1200
) (
    input  wire logic        mclk,
    input  wire logic        comparator_enable,
    input  wire logic        positive_input_select,
    input  wire logic [1:0]  negative_input_select,
    input  wire logic [15:0] pos_pin_mv,
    input  wire logic [15:0] other_pos_mv,
    input  wire logic [15:0] neg_pin_mv,
    output logic             compare_raw
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] vp;
    logic [15:0] vn;
    logic        wander = 1'b0;
    // Route both comparator inputs from the selects
    always_comb begin
        vp = positive_input_select ? VREF_MV[15:0] : pos_pin_mv;
        case (negative_input_select)
            2'h0: vn = neg_pin_mv;
            2'h1: vn = pos_pin_mv;
            2'h2: vn = other_pos_mv;
            default: vn = BG_MV[15:0];
        endcase
    end
    // A switched-off core gives no stable level
    always @(posedge mclk) wander <= ~wander;
    assign compare_raw = comparator_enable ? (vp > vn) : wander;
endmodule : acc_cmp_model
`default_nettype wire

// ==== bench/acc_top_asserts.sv ====
// Port-level checker of the comparator control block
`default_nettype none
module acc_top_asserts (
    input wire logic        mclk,
    input wire logic        rstn,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        comparator_enable,
    input wire logic        positive_input_select,
    input wire logic [1:0]  negative_input_select,
    input wire logic        comparator_output_pin,
    input wire logic        comparator_output_pin_oe,
    input wire logic        irq_pulse,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    logic ctl_wr;
    logic msk;
    assign ctl_wr = reg_wr && reg_addr == acc_pkg::ADDR_CONTROL;
    // Shadow of the interrupt mask bit
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) msk <= 1'b0;
        else if (reg_wr && reg_addr == acc_pkg::ADDR_IRQ_MASK) msk <= reg_wdata[0];
    end
    // =====================================================================
    // Properties
    // =====================================================================
    AST_EN_WR: assert property (ctl_wr |=> comparator_enable == $past(reg_wdata[15]))
        else $error("enable output differs from written bit");
    AST_OE_WR: assert property (ctl_wr |-> ##2 comparator_output_pin_oe == $past(reg_wdata[14], 2))
        else $error("pin enable differs from written bit");
    AST_PIN_OFF: assert property (!comparator_output_pin_oe && $past(!comparator_output_pin_oe) |-> !comparator_output_pin)
        else $error("pin driven while disabled");
    AST_POS_WR: assert property (ctl_wr |=> positive_input_select == $past(reg_wdata[4]))
        else $error("positive select differs from written bit");
    AST_NEG_WR: assert property (ctl_wr |=> negative_input_select == $past(reg_wdata[1:0]))
        else $error("negative select differs from written field");
    AST_UNIMPL: assert property ($past(reg_rd) && $past(reg_addr) == 8'h00 |-> (reg_rdata & 32'hFFFF_1E2C) == 32'h0000_0000)
        else $error("unimplemented control bit reads one");
    AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
        else $error("read data outside read slot");
    AST_PULSE: assert property (irq_pulse |=> !irq_pulse)
        else $error("request pulse longer than one cycle");
    AST_MASKED: assert property (!msk && !$past(msk) |-> !irq)
        else $error("interrupt raised while masked");
endmodule : acc_top_asserts
bind acc_top acc_top_asserts i_acc_top_asserts (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .comparator_enable(comparator_enable), .positive_input_select(positive_input_select),
    .negative_input_select(negative_input_select), .comparator_output_pin(comparator_output_pin),
    .comparator_output_pin_oe(comparator_output_pin_oe), .irq_pulse(irq_pulse), .irq(irq));
`default_nettype wire

// ==== bench/tb_top.sv ====
// Self-checking bench of the comparator control block
`default_nettype none
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin n_errors++; $display("[FAIL] %s exp %h got %h", nm, ex, gt); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] VREF = 16'h0672;
    localparam logic [15:0] BG   = 16'h04B0;
    logic mclk, rstn, reg_wr, reg_rd, raw, en, psel, pin, oe, irq_pulse, irq;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d, w, c;
    logic [1:0]  nsel;
    logic [15:0] pp, op, pn;
    int n_errors, check_count, pulses, cyc, er;
    acc_top i_acc_top (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .compare_raw(raw),
        .comparator_enable(en), .positive_input_select(psel), .negative_input_select(nsel),
        .comparator_output_pin(pin), .comparator_output_pin_oe(oe), .irq_pulse(irq_pulse), .irq(irq));
    acc_cmp_model #(.VREF_MV(1650), .BG_MV(1200)) i_acc_cmp_model (.mclk(mclk),
        .comparator_enable(en), .positive_input_select(psel), .negative_input_select(nsel),
        .pos_pin_mv(pp), .other_pos_mv(op), .neg_pin_mv(pn), .compare_raw(raw));
    // Processed result expected from the control image and input levels
    function automatic logic proc(input logic [31:0] k);
        logic [15:0] p;
        logic [15:0] n;
        p = k[4] ? VREF : pp;
        n = (k[1:0] == 2'h0) ? pn : (k[1:0] == 2'h1) ? pp : (k[1:0] == 2'h2) ? op : BG;
        return k[15] & ((p > n) ^ k[13]);
    endfunction : proc
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0; // Next access waits a cycle after every write
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    task automatic end_sim;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // Pulse counter and hang limit
    always @(posedge mclk) begin
        cyc++;
        if (irq_pulse === 1'b1) pulses++;
        if (cyc == 5000) begin
            n_errors++;
            end_sim();
        end
    end
    initial begin
        {rstn, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        pp = 16'd500;
        op = 16'd800;
        pn = 16'd1000;
        c = $urandom(93423);
        repeat (20) @(posedge mclk);
        rstn <= 1'b1;
        rd(acc_pkg::ADDR_CONTROL);
        `CHK("ctl_reset", 32'h0000_00C3, d)
        // Random control images over every input select code, enable on and off
        for (int i = 0; i < 16; i++) begin
            w = $urandom;
            w[15] = i[3];
            w[4] = i[2];
            w[1:0] = i[1:0];
            wr(acc_pkg::ADDR_CONTROL, w);
            c = w & 32'h0000_E0D3;
            repeat (8) @(posedge mclk);
            rd(acc_pkg::ADDR_CONTROL);
            `CHK("ctl_read", c | {23'h0, proc(c), 8'h00}, d)
            `CHK("pin", c[14] & proc(c), pin)
            `CHK("sel", {c[15], c[14], c[4], c[1:0]}, {en, oe, psel, nsel})
        end
        wr(8'h0C, 32'hFFFF_FFFF);
        rd(8'h0C);
        `CHK("unmapped", 32'h0000_0000, d)
        rd(acc_pkg::ADDR_CONTROL);
        `CHK("ctl_kept", c | {23'h0, proc(c), 8'h00}, d)
        // Every edge code with and without inversion
        for (int i = 0; i < 8; i++) begin
            wr(acc_pkg::ADDR_IRQ_MASK, {31'h0, i[2:1] != 2'h1});
            wr(acc_pkg::ADDR_CONTROL, {16'h0, 2'h2, i[0], 5'h0, i[2:1], 6'h0});
            repeat (10) @(posedge mclk);
            rd(acc_pkg::ADDR_IRQ_STATUS);
            pulses = 0;
            er = i[0] ? i[2] : i[1];
            pp <= 16'd1500;
            repeat (10) @(posedge mclk);
            #1 `CHK("pulse_rise", er, pulses)
            `CHK("irq", (er == 1) && (i[2:1] != 2'h1), irq)
            rd(acc_pkg::ADDR_IRQ_STATUS);
            `CHK("status", er[0], d[0])
            rd(acc_pkg::ADDR_IRQ_STATUS);
            `CHK("status_clr", 1'b0, d[0])
            pp <= 16'd500;
            repeat (10) @(posedge mclk);
            #1 `CHK("pulse_all", i[1] + i[2], pulses)
        end
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
